// ### emf_mac.sv
// ethernet mac datapath: tx fifo, checksum decision, rx fifo, counters
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "emf_consts.svh"
module emf_mac
  import emf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // tx words from dma
  input wire logic tx_in_valid,
  input wire emf_word_s tx_in,
  output logic tx_in_ready,
  // tx bytes to phy side
  output logic tx_out_valid,
  output logic [7:0] tx_out_byte,
  output logic tx_out_last,
  output logic tx_csum_insert,
  output logic tx_status,
  // rx words from phy side (pin domain)
  input wire logic rx_in_valid,
  input wire emf_word_s rx_in,
  input wire logic rx_crc_bad,
  input wire logic rx_unicast,
  // rx words to dma
  input wire logic rx_out_ready,
  output logic rx_out_valid,
  output emf_word_s rx_out,
  output logic rx_hdr_ok,
  // link clock enable
  output logic link_tick
);
  // ----------------------------------------
  // register port
  // ----------------------------------------
  logic [31:0] opmode;
  logic [31:0] ctrl;
  logic [31:0] txdesc;
  logic [31:0] rxdesc;
  logic [31:0] crc_err_cnt;
  logic [31:0] ucast_cnt;
  logic flush;
  emf_rd_e rd_state;
  wire logic wr_ctrl = reg_wr && reg_addr == `EMF_REG_CTRL;
  wire logic wr_op = reg_wr && reg_addr == `EMF_REG_OPMODE;
  wire logic wr_txd = reg_wr && reg_addr == `EMF_REG_TXDESC;
  wire logic wr_rxd = reg_wr && reg_addr == `EMF_REG_RXDESC;
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `EMF_REG_CTRL: rd_mux = ctrl;
      `EMF_REG_STAT: rd_mux = {30'h00000000, rd_state};
      `EMF_REG_CRCERR: rd_mux = crc_err_cnt;
      `EMF_REG_UCAST: rd_mux = ucast_cnt;
      `EMF_REG_RXDESC: rd_mux = rxdesc;
      `EMF_REG_OPMODE: rd_mux = opmode;
      `EMF_REG_TXDESC: rd_mux = txdesc;
      `EMF_REG_ID: rd_mux = `EMF_ID_VALUE;
      default: rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
      opmode <= 32'h00000000;
      ctrl <= 32'h00000000;
      txdesc <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
      if (wr_op) opmode <= reg_wdata;
      if (wr_ctrl) ctrl <= {reg_wdata[31:1], 1'b0};
      if (wr_txd) txdesc <= reg_wdata;
    end
  end
  // flush is a one-cycle strobe from the control write
  assign flush = wr_ctrl && reg_wdata[`EMF_FLUSH_BIT];
  wire logic tx_store_forward_enable = opmode[`EMF_TSF_BIT];
  wire logic rsf = opmode[`EMF_RSF_BIT];
  // ----------------------------------------
  // tx fifo
  // ----------------------------------------
  emf_word_s tx_mem [`EMF_FIFO_DEPTH];
  logic [`EMF_FIFO_AW:0] tx_wp;
  logic [`EMF_FIFO_AW:0] tx_rp;
  logic [`EMF_FIFO_AW:0] tx_eofs;
  wire logic tx_empty = tx_wp == tx_rp;
  wire logic tx_full = (tx_wp - tx_rp) == 5'(`EMF_FIFO_DEPTH);
  wire logic tx_push = tx_in_valid && !tx_full;
  wire emf_word_s tx_head = tx_mem[tx_rp[`EMF_FIFO_AW-1:0]];
  logic [1:0] bsel;
  logic tx_pop;
  // ready comes from the next fill so it stays equal to not-full
  wire logic [`EMF_FIFO_AW:0] next_tx_fill = tx_wp - tx_rp + 5'(tx_push) - 5'(tx_pop);
  always_ff @(posedge clk) begin
    if (tx_push) tx_mem[tx_wp[`EMF_FIFO_AW-1:0]] <= tx_in;
  end
  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      tx_wp <= 5'h00;
      tx_rp <= 5'h00;
      tx_eofs <= 5'h00;
      tx_in_ready <= 1'b1;
    end else begin
      if (tx_push) tx_wp <= tx_wp + 5'h01;
      if (tx_pop) tx_rp <= tx_rp + 5'h01;
      tx_eofs <= tx_eofs + 5'(tx_push && tx_in.eof) - 5'(tx_pop && tx_head.eof);
      tx_in_ready <= next_tx_fill != 5'(`EMF_FIFO_DEPTH);
    end
  end
  // ----------------------------------------
  // tx read controller
  // ----------------------------------------
  // whole frame held, or threshold mode with any data; fifo running dry just stalls
  wire logic can_start = tx_store_forward_enable ? (tx_eofs != 5'h00) : !tx_empty;
  wire logic last_byte = bsel == (tx_head.nbytes - 2'h1);
  logic fcs_phase;
  // a queued frame must not be drained while the fcs bytes go out
  wire logic sending = rd_state == EMF_RD_SEND && !fcs_phase && !tx_empty && !flush;
  assign tx_pop = sending && last_byte;
  wire logic frame_end = tx_pop && tx_head.eof;
  wire logic crc_on = !txdesc[`EMF_CRCDIS_BIT];
  logic [1:0] fcs_idx;
  logic [31:0] fcs;
  emf_rd_e next_rd;
  always_comb begin
    case (rd_state)
      EMF_RD_IDLE: next_rd = can_start ? EMF_RD_SEND : EMF_RD_IDLE;
      EMF_RD_WAIT: next_rd = EMF_RD_IDLE;
      EMF_RD_SEND: next_rd = frame_end && !crc_on ? EMF_RD_STAT : EMF_RD_SEND;
      EMF_RD_STAT: next_rd = EMF_RD_WAIT;
      default: next_rd = EMF_RD_IDLE;
    endcase
  end
  // flush always lands in idle and idle re-evaluates every cycle, so no stuck case
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_state <= EMF_RD_IDLE;
      bsel <= 2'h0;
      fcs_phase <= 1'b0;
      fcs_idx <= 2'h0;
    end else if (flush) begin
      rd_state <= EMF_RD_IDLE;
      bsel <= 2'h0;
      fcs_phase <= 1'b0;
      fcs_idx <= 2'h0;
    end else if (fcs_phase) begin
      fcs_idx <= fcs_idx + 2'h1;
      if (fcs_idx == 2'h3) begin
        fcs_phase <= 1'b0;
        rd_state <= EMF_RD_STAT;
      end
    end else begin
      rd_state <= next_rd;
      if (sending) bsel <= last_byte ? 2'h0 : bsel + 2'h1;
      if (frame_end && crc_on) fcs_phase <= 1'b1;
    end
  end
  wire logic [7:0] cur_byte = tx_head.data[8*bsel +: 8];
  wire logic first_byte = tx_head.sof && bsel == 2'h0;
  emf_crc32 u_crc (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(first_byte),
    .byte_en(sending),
    .byte_in(cur_byte),
    .crc(fcs)
  );
  // ----------------------------------------
  // tx checksum decision on the frame head
  // ----------------------------------------
  // byte 12..13 ethertype, byte 20 ipv6 next header, in word 3 and 5
  logic is_v6;
  logic [7:0] v6_nh;
  wire logic nh_l4 = v6_nh == `EMF_NH_TCP || v6_nh == `EMF_NH_UDP || v6_nh == `EMF_NH_ICMP;
  wire logic cic_on = txdesc[`EMF_CIC_HI:`EMF_CIC_LO] != 2'h0;
  logic [2:0] txw;
  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      txw <= 3'h0;
      is_v6 <= 1'b0;
      v6_nh <= 8'hff;
    end else if (tx_pop) begin
      txw <= tx_head.eof ? 3'h0 : (txw == 3'h7 ? txw : txw + 3'h1);
      if (txw == 3'h3) is_v6 <= tx_head.data[15:0] == 16'hdd86;
      if (txw == 3'h5) v6_nh <= tx_head.data[7:0];
    end
  end
  // ----------------------------------------
  // tx outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_out_valid <= 1'b0;
      tx_out_byte <= 8'h00;
      tx_out_last <= 1'b0;
      tx_status <= 1'b0;
      tx_csum_insert <= 1'b0;
    end else begin
      tx_out_valid <= sending || fcs_phase;
      tx_out_byte <= fcs_phase ? fcs[8*fcs_idx +: 8] : cur_byte;
      tx_out_last <= fcs_phase ? fcs_idx == 2'h3 : frame_end && !crc_on;
      tx_status <= rd_state == EMF_RD_STAT;
      // v6 without l4 payload goes out untouched
      tx_csum_insert <= cic_on && (!is_v6 || nh_l4);
    end
  end
  // ----------------------------------------
  // rx input synchronisers
  // ----------------------------------------
  logic [1:0] rxv_s;
  emf_word_s rxd_s0;
  emf_word_s rxd_s1;
  logic [1:0] rxb_s0;
  logic [1:0] rxb_s1;
  always_ff @(posedge clk) begin
    rxv_s <= {rxv_s[0], rx_in_valid};
    rxd_s0 <= rx_in;
    rxd_s1 <= rxd_s0;
    rxb_s0 <= {rx_crc_bad, rx_unicast};
    rxb_s1 <= rxb_s0;
  end
  wire logic rxv = rxv_s[1];
  // ----------------------------------------
  // rx fifo with threshold overflow
  // ----------------------------------------
  emf_word_s rx_mem [`EMF_FIFO_DEPTH];
  logic [`EMF_FIFO_AW:0] rx_wp;
  logic [`EMF_FIFO_AW:0] rx_rp;
  logic ovf_drop;
  wire logic [`EMF_FIFO_AW:0] rx_free = 5'(`EMF_FIFO_DEPTH) - (rx_wp - rx_rp);
  // non-eof word with two free declares overflow; eof keeps a spare slot
  wire logic ovf_hit = rxv && !rxd_s1.eof && rx_free <= `EMF_OVF_FREE && !rsf;
  wire logic rx_push = rxv && !ovf_hit && !ovf_drop && rx_free != 5'h00;
  wire logic rx_pop = rx_out_valid && rx_out_ready;
  always_ff @(posedge clk) begin
    if (rx_push) rx_mem[rx_wp[`EMF_FIFO_AW-1:0]] <= rxd_s1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_wp <= 5'h00;
      rx_rp <= 5'h00;
      ovf_drop <= 1'b0;
      rxdesc <= 32'h00000000;
    end else begin
      if (rx_push) rx_wp <= rx_wp + 5'h01;
      if (rx_pop) rx_rp <= rx_rp + 5'h01;
      // drop rest of frame; eof closes it, the flag still set whatever the length
      if (rxv && rxd_s1.eof) ovf_drop <= 1'b0;
      else if (ovf_hit) ovf_drop <= 1'b1;
      // hardware set of the overflow bit wins over a software write
      if (wr_rxd) rxdesc <= reg_wdata;
      if (ovf_hit || (ovf_drop && rxv)) rxdesc[`EMF_OE_BIT] <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_out_valid <= 1'b0;
      rx_out <= '0;
    end else if (!rx_out_valid || rx_out_ready) begin
      rx_out_valid <= (rx_wp != rx_rp) && !(rx_pop && rx_wp == rx_rp + 5'h01);
      rx_out <= rx_mem[rx_rp[`EMF_FIFO_AW-1:0] + (rx_pop ? 4'h1 : 4'h0)];
    end
  end
  // ----------------------------------------
  // rx ipv6 extension header walk
  // ----------------------------------------
  // header walk is done on words 5 to 14; extension length ignored, small model
  logic [3:0] rxw;
  logic seen_ext;
  logic hdr_ok;
  wire logic [7:0] rx_nh = rxd_s1.data[7:0];
  wire logic nh_hop = rx_nh == `EMF_NH_HOP;
  wire logic nh_rd = rx_nh == `EMF_NH_ROUTE || rx_nh == `EMF_NH_DEST;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxw <= 4'h0;
      seen_ext <= 1'b0;
      hdr_ok <= 1'b1;
      rx_hdr_ok <= 1'b0;
    end else if (rxv) begin
      rxw <= rxd_s1.eof ? 4'h0 : (rxw == 4'hf ? rxw : rxw + 4'h1);
      if (rxd_s1.sof) begin
        seen_ext <= 1'b0;
        hdr_ok <= 1'b1;
      end else if (rxw >= 4'h5 && rxw < 4'hf) begin
        if (nh_hop && seen_ext) hdr_ok <= 1'b0;
        if (nh_hop || nh_rd) seen_ext <= 1'b1;
      end
      if (rxd_s1.eof) rx_hdr_ok <= hdr_ok;
    end
  end
  // ----------------------------------------
  // management counters
  // ----------------------------------------
  wire logic rx_eof = rxv && rxd_s1.eof;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      crc_err_cnt <= 32'h00000000;
      ucast_cnt <= 32'h00000000;
    end else if (rx_eof) begin
      if (rxb_s1[1]) crc_err_cnt <= crc_err_cnt + 32'h1;
      if (!rxb_s1[1] && rxb_s1[0]) ucast_cnt <= ucast_cnt + 32'h1;
    end
  end
  // ----------------------------------------
  // rmii reference divider
  // ----------------------------------------
  emf_rmii_div u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .rmii_mode(ctrl[`EMF_RMII_BIT]),
    .speed100(ctrl[`EMF_SPEED100_BIT]),
    .tick(link_tick)
  );
endmodule // emf_mac

// ### emf_consts.svh
// constants of the ethernet mac fifo and checksum block
// ----------------------------------------
// Contract
// - each tx frame picks checksum insertion through descriptor word zero control field.
// - ipv6 frame without tcp, udp or icmp payload passes unmodified.
// - rx parser steps over hop-by-hop, routing and destination options headers.
// - routing and destination repeat freely; hop-by-hop valid only right after main header.
// - tx flush stops data mid-frame, read state goes idle, then resumes.
// - flush one cycle after tx status must not leave controller stuck idle.
// - reset returns the tx read controller to normal operation.
// - store-and-forward starts a frame only when whole packet is in fifo.
// - tx data stays intact while fifo toggles empty and non-empty.
// - with crc insertion, fcs is computed over sent data and appended.
// - threshold mode overflow when non-eof word arrives with two locations free.
// - overflow sets the error bit of rx descriptor word zero.
// - overflow reported right, unread data never overwritten, also for length 4n+1.
// - rmii 50 mhz reference divided by two at 100m, twenty at 10m.
// - mii mode uses pad clock directly with no division.
// - counter of rx frames with crc error, readable.
// - counter of rx good unicast frames, readable.
// ----------------------------------------
`ifndef EMF_CONSTS_SVH
`define EMF_CONSTS_SVH
`define EMF_REG_CTRL 4'h0
`define EMF_REG_STAT 4'h1
`define EMF_REG_CRCERR 4'h2
`define EMF_REG_UCAST 4'h3
`define EMF_REG_RXDESC 4'h4
`define EMF_REG_OPMODE 4'h5
`define EMF_REG_TXDESC 4'h6
`define EMF_REG_ID 4'h7
`define EMF_ID_VALUE 32'h00c0ffee
`define EMF_TSF_BIT 0
`define EMF_RSF_BIT 1
`define EMF_FLUSH_BIT 0
`define EMF_RMII_BIT 1
`define EMF_SPEED100_BIT 2
`define EMF_CIC_LO 22
`define EMF_CIC_HI 23
`define EMF_CRCDIS_BIT 27
`define EMF_OE_BIT 11
`define EMF_FIFO_DEPTH 16
`define EMF_FIFO_AW 4
`define EMF_OVF_FREE 5'h02
`define EMF_DIV100 5'h02
`define EMF_DIV10 5'h14
`define EMF_NH_HOP 8'h00
`define EMF_NH_ROUTE 8'h2b
`define EMF_NH_DEST 8'h3c
`define EMF_NH_TCP 8'h06
`define EMF_NH_UDP 8'h11
`define EMF_NH_ICMP 8'h3a
`define EMF_CRC_INIT 32'hffffffff
`define EMF_CRC_POLY 32'hedb88320
`endif

// ### emf_pkg.sv
// types shared by the ethernet mac fifo and checksum block
package emf_pkg;
  typedef enum logic [1:0] {
    EMF_RD_IDLE = 2'b00,
    EMF_RD_WAIT = 2'b01,
    EMF_RD_SEND = 2'b10,
    EMF_RD_STAT = 2'b11
  } emf_rd_e;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] nbytes;
    logic sof;
    logic eof;
  } emf_word_s;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } emf_bus_s;
endpackage

// ### emf_crc32.sv
// byte-wise crc32 engine for the frame check sequence
`timescale 1ns/1ps
`include "emf_consts.svh"
module emf_crc32
  import emf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  input wire logic byte_en,
  input wire logic [7:0] byte_in,
  // result
  output logic [31:0] crc
);
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `EMF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  logic [31:0] state;
  wire logic [31:0] next_state = start ? crc_byte(`EMF_CRC_INIT, byte_in)
                                       : crc_byte(state, byte_in);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= `EMF_CRC_INIT;
    end else if (byte_en) begin
      state <= next_state;
    end
  end
  assign crc = ~state;
endmodule // emf_crc32

// ### emf_rmii_div.sv
// link clock enable divider for rmii and mii
`timescale 1ns/1ps
`include "emf_consts.svh"
module emf_rmii_div
  import emf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // mode
  input wire logic rmii_mode,
  input wire logic speed100,
  // tick out
  output logic tick
);
  logic [4:0] cnt;
  // divide by two or twenty in rmii, pass every cycle in mii
  wire logic [4:0] div = speed100 ? `EMF_DIV100 : `EMF_DIV10;
  wire logic wrap = (cnt >= div - 5'h01);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt <= 5'h00;
      tick <= 1'b0;
    end else if (!rmii_mode) begin
      cnt <= 5'h00;
      tick <= 1'b1;
    end else begin
      cnt <= wrap ? 5'h00 : cnt + 5'h01;
      tick <= wrap;
    end
  end
endmodule // emf_rmii_div

// ### emf_mac_sva.sv
// port checker for emf_mac
`timescale 1ns/1ps
`include "emf_consts.svh"
module emf_mac_sva
  import emf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // tx side
  input wire logic tx_in_valid,
  input wire emf_word_s tx_in,
  input wire logic tx_in_ready,
  input wire logic tx_out_valid,
  input wire logic tx_out_last,
  input wire logic tx_csum_insert,
  input wire logic tx_status,
  // link
  input wire logic link_tick
);
  // ----------
  // mirror of software settings
  // ----------
  logic rmii;
  logic spd;
  logic tx_store_forward_enable;
  logic [1:0] checksum_insert_control;
  logic [5:0] age;
  logic [5:0] gap;
  logic [3:0] pend;
  wire ctrl_wr = reg_wr && reg_addr == `EMF_REG_CTRL;
  wire flush_wr = ctrl_wr && reg_wdata[`EMF_FLUSH_BIT];
  wire eof_in = tx_in_valid && tx_in_ready && tx_in.eof;
  wire fr_end = tx_out_valid && tx_out_last;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {rmii, spd, tx_store_forward_enable, checksum_insert_control, age, gap, pend} <= '0;
    end else begin
      if (ctrl_wr) begin
        rmii <= reg_wdata[`EMF_RMII_BIT];
        spd <= reg_wdata[`EMF_SPEED100_BIT];
      end
      if (reg_wr && reg_addr == `EMF_REG_OPMODE) tx_store_forward_enable <= reg_wdata[`EMF_TSF_BIT];
      if (reg_wr && reg_addr == `EMF_REG_TXDESC) checksum_insert_control <= reg_wdata[`EMF_CIC_HI:`EMF_CIC_LO];
      // divider phase may wander after a mode change, so age gates the checks
      age <= ctrl_wr ? 6'h0 : age + 6'(age != 6'h3f);
      gap <= link_tick ? 6'h1 : gap + 6'(gap != 6'h3f);
      // frames whose last word is queued; flush drops them all
      pend <= flush_wr ? 4'h0 : pend + 4'(eof_in) - 4'(fr_end);
    end
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read answer");
  unmapped_zero_a: assert property ($past(reg_rd) && $past(reg_addr) > 4'h7 |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  status_pulse_a: assert property (fr_end |=> tx_status ##1 !tx_status)
    else $error("no single status pulse after frame");
  status_cause_a: assert property (tx_status |-> $past(fr_end))
    else $error("status without frame end");
  flush_stop_a: assert property (flush_wr |-> ##[1:3] !tx_out_valid)
    else $error("flush did not stop data");
  store_fwd_a: assert property (tx_store_forward_enable && tx_out_valid |-> pend != 4'h0)
    else $error("byte sent before whole frame queued");
  csum_ctl_a: assert property (tx_csum_insert |-> $past(checksum_insert_control) != 2'h0)
    else $error("checksum inserted while disabled");
  mii_tick_a: assert property (!rmii && age > 6'd30 |-> link_tick)
    else $error("mii tick missing");
  div2_a: assert property (rmii && spd && age > 6'd30 && link_tick |=> !link_tick ##1 link_tick)
    else $error("divide by two wrong");
  div20_a: assert property (rmii && !spd && age > 6'd40 && link_tick |-> gap == 6'd20)
    else $error("divide by twenty wrong");
  cover property (flush_wr && tx_out_valid);
  cover property (fr_end && tx_store_forward_enable);
  cover property (rmii && !spd && link_tick);
endmodule // emf_mac_sva

bind emf_mac emf_mac_sva emf_mac_sva_i (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .tx_in_valid, .tx_in, .tx_in_ready, .tx_out_valid, .tx_out_last,
  .tx_csum_insert, .tx_status, .link_tick);

// ### emf_phy_model.sv
// phy side model feeding receive words
`timescale 1ns/1ps
module emf_phy_model
  import emf_pkg::*;
(
  // clock
  input wire logic clk,
  // receive lines toward the mac
  output logic rx_in_valid,
  output emf_word_s rx_in,
  output logic rx_crc_bad,
  output logic rx_unicast
);
  logic busy = 1'b0;
  initial {rx_in_valid, rx_in, rx_crc_bad, rx_unicast} = '0;
  // idle data keeps moving so a stale word is never mistaken for a held one
  always @(posedge clk) if (!busy) rx_in.data <= ~rx_in.data;
  task automatic send(input int n, input logic [31:0] base, input logic bad, input logic uc,
      input logic [1:0] nb);
    busy = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_in_valid <= 1'b1;
      rx_in <= '{base + 32'(i), i == n - 1 ? nb : 2'h0, i == 0, i == n - 1};
      rx_crc_bad <= bad && i == n - 1;
      rx_unicast <= uc && i == n - 1;
    end
    @(posedge clk);
    rx_in_valid <= 1'b0;
    {rx_crc_bad, rx_unicast} <= 2'b00;
    busy = 1'b0;
  endtask
endmodule // emf_phy_model

// ### emf_mac_bench.sv
// self-checking bench for emf_mac
`timescale 1ns/1ps
`include "emf_consts.svh"
module emf_mac_bench
  import emf_pkg::*;
;
  logic clk;
  logic sys_rst;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic tx_in_valid;
  emf_word_s tx_in;
  logic tx_in_ready;
  logic tx_out_valid;
  logic [7:0] tx_out_byte;
  logic tx_out_last;
  logic tx_csum_insert;
  logic tx_status;
  logic rx_in_valid;
  emf_word_s rx_in;
  logic rx_crc_bad;
  logic rx_unicast;
  logic rx_out_ready;
  logic rx_out_valid;
  emf_word_s rx_out;
  logic rx_hdr_ok;
  logic link_tick;
  logic [31:0] exp_rd[$];
  logic [31:0] exp_tx[$];
  logic [31:0] exp_rx[$];
  int err_count = 0;
  int n_checks = 0;
  bit chk_tx = 1'b1;
  bit chk_rx = 1'b0;
  logic rd_q = 1'b0;
  emf_mac emf_mac_i (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tx_in_valid, .tx_in, .tx_in_ready, .tx_out_valid, .tx_out_byte, .tx_out_last,
    .tx_csum_insert, .tx_status, .rx_in_valid, .rx_in, .rx_crc_bad, .rx_unicast,
    .rx_out_ready, .rx_out_valid, .rx_out, .rx_hdr_ok, .link_tick);
  emf_phy_model emf_phy_model_i (.clk, .rx_in_valid, .rx_in, .rx_crc_bad, .rx_unicast);
  // ----------
  // helpers
  // ----------
  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_for(input int kind);
    int t;
    for (t = 0; t < 3000; t++) begin
      @(posedge clk);
      if (kind == 0 ? tx_in_ready : kind == 1 ? tx_status : kind == 2 ? tx_out_valid :
          kind == 3 ? rx_out_valid && rx_out.eof : !rx_out_valid) break;
    end
    if (t == 3000) begin
      err_count++;
      $display("wrong value at %0t: wait %0d ran out", $time, kind);
      wrap_up();
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d, input bit now = 0);
    if (!now) @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_rd.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `EMF_CRC_POLY : c >> 1;
    return c;
  endfunction
  task automatic push_tx(input int n, input logic [1:0] nb, input bit fcs, input bit gaps,
      input bit v6 = 1'b0);
    logic [31:0] w;
    logic [31:0] c;
    int cnt;
    c = `EMF_CRC_INIT;
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      w = $urandom;
      // ipv6 ethertype, then a next header with no l4 payload
      if (v6 && i == 3) w[15:0] = 16'hdd86;
      if (v6 && i == 5) w[7:0] = 8'h3b;
      cnt = (i == n - 1 && nb != 2'h0) ? int'(nb) : 4;
      for (int k = 0; k < cnt; k++) begin
        c = crc_byte(c, w[8*k+:8]);
        exp_tx.push_back({23'h0, !fcs && i == n - 1 && k == cnt - 1, w[8*k+:8]});
      end
      tx_in_valid <= 1'b1;
      tx_in <= '{w, i == n - 1 ? nb : 2'h0, i == 0, i == n - 1};
      wait_for(0);
      // a short empty spell between words
      if (gaps && $urandom_range(1) == 1) begin
        tx_in_valid <= 1'b0;
        @(posedge clk);
      end
    end
    tx_in_valid <= 1'b0;
    for (int k = 0; k < 4 && fcs; k++) exp_tx.push_back({23'h0, k == 3, ~c[8*k+:8]});
  endtask
  task automatic frame(input int n, input logic [1:0] nb, input bit fcs, input bit gaps,
      input logic [1:0] checksum_insert_control, input bit v6 = 1'b0);
    reg_write(`EMF_REG_TXDESC, (32'(!fcs) << `EMF_CRCDIS_BIT) | (32'(checksum_insert_control) << `EMF_CIC_LO));
    push_tx(n, nb, fcs, gaps, v6);
    wait_for(1);
    check(32'(tx_csum_insert), 32'(checksum_insert_control != 2'h0 && !v6), "csum");
  endtask
  // ----------
  // result watcher
  // ----------
  always @(posedge clk) begin
    rd_q <= reg_rd;
    if (rd_q) check(reg_rdata, exp_rd.pop_front(), "reg");
    if (chk_tx && tx_out_valid)
      check({23'h0, tx_out_last, tx_out_byte}, exp_tx.pop_front(), "tx");
    if (chk_rx && rx_out_valid && rx_out_ready)
      check(rx_out.data, exp_rx.pop_front(), "rx");
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    logic [31:0] base;
    {reg_addr, reg_wdata, reg_wr, reg_rd, tx_in_valid, tx_in} = '0;
    sys_rst = 1'b1;
    rx_out_ready = 1'b1;
    void'($urandom(32'h74cb5f8f));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    reg_read(`EMF_REG_STAT, 32'h0);
    reg_read(`EMF_REG_CRCERR, 32'h0);
    reg_read(`EMF_REG_ID, `EMF_ID_VALUE);
    reg_read(4'hc, 32'h0);
    for (int m = 0; m < 3; m++) begin
      reg_write(`EMF_REG_CTRL, m == 0 ? 32'h6 : m == 1 ? 32'h2 : 32'h0);
      repeat (80) @(posedge clk);
    end
    reg_write(`EMF_REG_OPMODE, 32'h1);
    reg_read(`EMF_REG_OPMODE, 32'h1);
    for (int c = 0; c < 4; c++) frame(3, 2'(c), 1'b1, 1'b0, 2'(c));
    reg_write(`EMF_REG_OPMODE, 32'h0);
    frame(5, 2'h1, 1'b0, 1'b1, 2'h0);
    reg_write(`EMF_REG_CTRL, 32'h1, 1'b1);
    reg_read(`EMF_REG_STAT, 32'h0);
    frame(2, 2'h3, 1'b1, 1'b0, 2'h0);
    for (int r = 0; r < 2; r++) begin
      chk_tx = 1'b0;
      push_tx(6, 2'h0, 1'b1, 1'b0);
      wait_for(2);
      if (r == 0) begin
        reg_write(`EMF_REG_CTRL, 32'h1, 1'b1);
      end else begin
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
      end
      repeat (4) @(posedge clk);
      exp_tx.delete();
      chk_tx = 1'b1;
      reg_read(`EMF_REG_STAT, 32'h0);
      frame(2, 2'h2, 1'b1, 1'b0, 2'h1);
    end
    frame(6, 2'h0, 1'b1, 1'b0, 2'h3, 1'b1);
    reg_write(`EMF_REG_OPMODE, 32'h2);
    emf_phy_model_i.send(3, $urandom, 1'b1, 1'b0, 2'h1);
    emf_phy_model_i.send(2, $urandom, 1'b1, 1'b1, 2'h0);
    emf_phy_model_i.send(4, $urandom, 1'b0, 1'b1, 2'h3);
    wait_for(3);
    reg_read(`EMF_REG_CRCERR, 32'h2);
    reg_read(`EMF_REG_UCAST, 32'h1);
    // threshold mode with a stalled reader: 21 words, last holds one byte
    reg_write(`EMF_REG_OPMODE, 32'h0);
    rx_out_ready <= 1'b0;
    base = $urandom;
    for (int i = 0; i < 21; i++) exp_rx.push_back(base + 32'(i));
    emf_phy_model_i.send(21, base, 1'b0, 1'b0, 2'h1);
    reg_read(`EMF_REG_RXDESC, 32'h1 << `EMF_OE_BIT);
    chk_rx = 1'b1;
    rx_out_ready <= 1'b1;
    wait_for(4);
    check(32'(exp_rx.size() == 7), 32'h1, "rx kept");
    exp_rx.delete();
    reg_write(`EMF_REG_RXDESC, 32'h0);
    reg_read(`EMF_REG_RXDESC, 32'h0);
    // low byte of word 5 is a hop-by-hop code in the first extension slot
    base = {24'($urandom), 8'hfb};
    for (int i = 0; i < 8; i++) exp_rx.push_back(base + 32'(i));
    emf_phy_model_i.send(8, base, 1'b0, 1'b1, 2'h1);
    wait_for(3);
    check(32'(rx_hdr_ok), 32'h1, "hdr");
    reg_read(`EMF_REG_UCAST, 32'h2);
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule // emf_mac_bench
